// ### logic/rx_port_pkg.sv
// Constants, types and register map for the receiver sample-input and parallel output ports.
// Assumes a single 40 MHz processing clock and an APB master with 32-bit data.
package rx_port_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] SCALE_IDX = 12'h309;
  localparam logic [11:0] CTRL_IDX = 12'h30a;
  localparam logic [11:0] STAT_IDX = 12'h30b;
  localparam logic [13:0] SCALE_ADDR = {SCALE_IDX, 2'b00};
  localparam logic [13:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [13:0] STAT_ADDR = {STAT_IDX, 2'b00};
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SOFTRST_BIT = 8;
  localparam int STAT_PAR_BIT = 0;
  localparam int STAT_PRIMED_BIT = 1;
  localparam int STAT_CNT_LSB = 4;
  // Reset values
  localparam logic [2:0] SCALE_RST = 3'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  // Pipeline flush depth after soft reset, in accepted samples
  localparam logic [2:0] PRIME_SAMPLES = 3'h7;
  // Widths
  localparam int MANT_W = 16;
  localparam int EXP_W = 3;
  localparam int RES_W = 23;
  // Timing: hard reset low time and the clock rate
  localparam int RESET_LOW_NS = 30;
  localparam int CLK_MHZ = 40;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
  // Settle time of the two-stage pin synchroniser before the strap is read
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Input modes
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_DIVERSITY = 2'b01,
    MODE_COMPLEX = 2'b10
  } inMode_t;
endpackage

// ### logic/pin_sync.sv
// Two-stage synchroniser for a bus of pins arriving from outside the clock domain.
// Assumes the bus is quasi-static around the sampling edge, as the converter guarantees.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] meta_q; // First stage, read only by the second
  logic [W-1:0] sync_q; // Second stage

  // Both stages clear to zero on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  assign pinOut = sync_q;
endmodule // pin_sync

// ### logic/out_scaler.sv
// Output word scaler: shifts a wide filter result and saturates it to 16 bits.
// Assumes two's complement input; the shift amount is the programmed scale field.
`timescale 1ns/1ps
module out_scaler
  import rx_port_pkg::*;
(
  input wire logic [RES_W-1:0] rawWord,
  input wire logic [2:0] scaleSel,
  output logic [15:0] scaledWord
);
  logic signed [RES_W-1:0] shifted; // Arithmetic shift of the raw result
  logic [RES_W-16:0] topBits; // Sign of the window and every bit above it

  // Larger scale drops more low bits; saturation keeps the sign, never wraps
  always_comb begin
    shifted = $signed(rawWord) >>> scaleSel;
    topBits = shifted[RES_W-1:15];
    if (topBits == '0 || topBits == '1) begin
      scaledWord = shifted[15:0];
    end else if (shifted[RES_W-1]) begin
      scaledWord = 16'h8000;
    end else begin
      scaledWord = 16'h7fff;
    end
  end
endmodule // out_scaler

// ### logic/rx_ports.sv
// Sample-input port and 16-bit parallel output port of the receive processor.
// Assumes converter pins are asynchronous to clk and filter results arrive on clk.
`timescale 1ns/1ps
module rx_ports
  import rx_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [MANT_W-1:0] mantissa,
  input wire logic [EXP_W-1:0] exponent,
  input wire logic chanSelect,
  input wire logic outputPortSelect,
  output logic sampleValid,
  output logic [MANT_W-1:0] sampleData,
  output logic [EXP_W-1:0] sampleExp,
  output logic sampleChanB,
  output logic sampleQuad,
  output logic [MANT_W-1:0] samplePairI,
  input wire logic resStrobe,
  input wire logic [RES_W-1:0] resIA,
  input wire logic [RES_W-1:0] resQA,
  input wire logic [RES_W-1:0] resIB,
  input wire logic [RES_W-1:0] resQB,
  output logic [15:0] outData,
  output logic outputValid,
  output logic iqFlag,
  output logic chanFlag,
  output logic parallelEnable
);
  // ---------------- Pin synchronisers ----------------
  logic [MANT_W+EXP_W:0] pinBus; // Strobe, exponent and mantissa after two stages
  logic strapSync; // Port-select strap after two stages
  logic strobeS;
  logic [EXP_W-1:0] expS;
  logic [MANT_W-1:0] mantS;

  // All converter pins pass the same two stages so they stay aligned
  pin_sync #(.W(MANT_W + EXP_W + 1)) inSync (
    .clk(clk),
    .resetn(resetn),
    .pinIn({chanSelect, exponent, mantissa}),
    .pinOut(pinBus)
  );
  pin_sync #(.W(1)) strapSyncInst (
    .clk(clk),
    .resetn(resetn),
    .pinIn(outputPortSelect),
    .pinOut(strapSync)
  );
  assign {strobeS, expS, mantS} = pinBus;

  // ---------------- Register file ----------------
  logic [2:0] scale_q, scale_d; // Output scale field
  inMode_t mode_q, mode_d; // Input mode
  logic softRst_q, softRst_d; // One-cycle soft reset pulse
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic pready_q;
  logic setup; // Setup phase of a transfer
  logic wrAccess; // Write completing this edge
  logic primed; // Flush finished
  logic [2:0] primeCnt_q, primeCnt_d; // Accepted samples since soft reset
  logic parMode_q, parMode_d; // Latched output-port mode
  logic strapDone_q, strapDone_d;
  logic [1:0] strapCnt_q, strapCnt_d;

  assign setup = psel && !penable;
  assign wrAccess = psel && penable && pwrite && pready_q;
  assign primed = (primeCnt_q == PRIME_SAMPLES);

  // Decode, writes and registered read data; read data set up one cycle early
  always_comb begin
    scale_d = scale_q;
    mode_d = mode_q;
    softRst_d = 1'b0;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      pslverr_d = 1'b0;
      prdata_d = 32'h0;
      unique case (paddr)
        SCALE_ADDR: prdata_d[2:0] = scale_q;
        CTRL_ADDR: prdata_d[CTRL_MODE_LSB +: 2] = mode_q;
        STAT_ADDR: begin
          prdata_d[STAT_PAR_BIT] = parMode_q;
          prdata_d[STAT_PRIMED_BIT] = primed;
          prdata_d[STAT_CNT_LSB +: 3] = primeCnt_q;
        end
        default: pslverr_d = 1'b1; // Unmapped address
      endcase
    end
    if (wrAccess) begin
      if (paddr == SCALE_ADDR) begin
        scale_d = pwdata[2:0];
      end else if (paddr == CTRL_ADDR) begin
        // Code 3 is illegal and falls back to single real
        if (pwdata[CTRL_MODE_LSB +: 2] == 2'b11) begin
          mode_d = MODE_SINGLE;
        end else begin
          mode_d = inMode_t'(pwdata[CTRL_MODE_LSB +: 2]);
        end
        softRst_d = pwdata[CTRL_SOFTRST_BIT];
      end
    end
  end

  // Register file flops; slave answers with zero wait states after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scale_q <= SCALE_RST;
      mode_q <= inMode_t'(MODE_RST);
      softRst_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      scale_q <= scale_d;
      mode_q <= mode_d;
      softRst_q <= softRst_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q <= 1'b1;
    end
  end

  // ---------------- Output-port strap ----------------
  // Strap read once the synchroniser has settled after release, then frozen
  always_comb begin
    strapCnt_d = strapCnt_q;
    strapDone_d = strapDone_q;
    parMode_d = parMode_q;
    if (!strapDone_q) begin
      if (strapCnt_q == STRAP_SETTLE) begin
        parMode_d = strapSync;
        strapDone_d = 1'b1;
      end else begin
        strapCnt_d = strapCnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapCnt_q <= 2'h0;
      strapDone_q <= 1'b0;
      parMode_q <= 1'b0;
    end else begin
      strapCnt_q <= strapCnt_d;
      strapDone_q <= strapDone_d;
      parMode_q <= parMode_d;
    end
  end

  // ---------------- Input acceptance ----------------
  logic prevStrobe_q, prevStrobe_d; // Strobe level at the previous edge
  logic accept; // This edge takes a sample
  logic [MANT_W-1:0] iHold_q, iHold_d; // Last in-phase word for pairing
  logic sValid_q, sValid_d;
  logic [MANT_W-1:0] sData_q, sData_d;
  logic [EXP_W-1:0] sExp_q, sExp_d;
  logic sChanB_q, sChanB_d;
  logic sQuad_q, sQuad_d;
  logic [MANT_W-1:0] sPairI_q, sPairI_d;

  // Single real uses the strobe as an enable; the others take only level changes
  always_comb begin
    if (mode_q == MODE_SINGLE) begin
      accept = strobeS;
    end else begin
      accept = (strobeS != prevStrobe_q);
    end
    prevStrobe_d = strobeS;
    primeCnt_d = primeCnt_q;
    iHold_d = iHold_q;
    sValid_d = 1'b0;
    sData_d = sData_q;
    sExp_d = sExp_q;
    sChanB_d = sChanB_q;
    sQuad_d = sQuad_q;
    sPairI_d = sPairI_q;
    if (softRst_q) begin
      primeCnt_d = 3'h0;
      iHold_d = '0;
    end else if (accept) begin
      // Flushed samples still fill the pipe but are not passed on
      if (!primed) begin
        primeCnt_d = primeCnt_q + 3'h1;
      end
      sValid_d = primed;
      sData_d = mantS;
      sExp_d = expS;
      sChanB_d = (mode_q == MODE_DIVERSITY) && !strobeS;
      sQuad_d = (mode_q == MODE_COMPLEX) && !strobeS;
      if (mode_q == MODE_COMPLEX && strobeS) begin
        iHold_d = mantS;
      end
      sPairI_d = (mode_q == MODE_COMPLEX && !strobeS) ? iHold_q : mantS;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevStrobe_q <= 1'b0;
      primeCnt_q <= 3'h0;
      iHold_q <= '0;
      sValid_q <= 1'b0;
      sData_q <= '0;
      sExp_q <= '0;
      sChanB_q <= 1'b0;
      sQuad_q <= 1'b0;
      sPairI_q <= '0;
    end else begin
      prevStrobe_q <= prevStrobe_d;
      primeCnt_q <= primeCnt_d;
      iHold_q <= iHold_d;
      sValid_q <= sValid_d;
      sData_q <= sData_d;
      sExp_q <= sExp_d;
      sChanB_q <= sChanB_d;
      sQuad_q <= sQuad_d;
      sPairI_q <= sPairI_d;
    end
  end

  // ---------------- Parallel output sequencer ----------------
  logic [RES_W-1:0] words_q [4], words_d [4]; // Captured A I, A Q, B I, B Q
  logic [1:0] idx_q, idx_d; // Next word to drive
  logic busy_q, busy_d; // Words still pending
  logic outDiv_q, outDiv_d; // Current burst is diversity
  logic start; // New result accepted
  logic [RES_W-1:0] rawSel;
  logic [1:0] selIdx;
  logic [15:0] scaled;
  logic [15:0] outData_q, outData_d;
  logic valid_q, valid_d, iq_q, iq_d, chan_q, chan_d;

  // Results arriving mid-burst are dropped; decimation keeps them apart
  assign start = resStrobe && parMode_q && !busy_q;
  assign selIdx = start ? 2'h0 : idx_q;
  assign rawSel = start ? resIA : words_q[selIdx];

  out_scaler scaler (
    .rawWord(rawSel),
    .scaleSel(scale_q),
    .scaledWord(scaled)
  );

  // One word per clock; after the last Q word the bus holds and flags drop
  always_comb begin
    words_d = words_q;
    idx_d = idx_q;
    busy_d = busy_q;
    outDiv_d = outDiv_q;
    outData_d = outData_q;
    valid_d = 1'b0;
    iq_d = 1'b0;
    chan_d = 1'b0;
    if (start) begin
      words_d[0] = resIA;
      words_d[1] = resQA;
      words_d[2] = resIB;
      words_d[3] = resQB;
      outDiv_d = (mode_q == MODE_DIVERSITY);
    end
    if (start || busy_q) begin
      outData_d = scaled;
      valid_d = 1'b1;
      iq_d = !selIdx[0];
      chan_d = !selIdx[1];
      idx_d = selIdx + 2'h1;
      busy_d = (selIdx != ((start ? (mode_q == MODE_DIVERSITY) : outDiv_q) ? 2'h3 : 2'h1));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      words_q <= '{default: '0};
      idx_q <= 2'h0;
      busy_q <= 1'b0;
      outDiv_q <= 1'b0;
      outData_q <= 16'h0;
      valid_q <= 1'b0;
      iq_q <= 1'b0;
      chan_q <= 1'b0;
    end else begin
      words_q <= words_d;
      idx_q <= idx_d;
      busy_q <= busy_d;
      outDiv_q <= outDiv_d;
      outData_q <= outData_d;
      valid_q <= valid_d;
      iq_q <= iq_d;
      chan_q <= chan_d;
    end
  end

  // ---------------- Port wiring ----------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sampleValid = sValid_q;
  assign sampleData = sData_q;
  assign sampleExp = sExp_q;
  assign sampleChanB = sChanB_q;
  assign sampleQuad = sQuad_q;
  assign samplePairI = sPairI_q;
  assign outData = outData_q;
  assign outputValid = valid_q;
  assign iqFlag = iq_q;
  assign chanFlag = chan_q;
  assign parallelEnable = parMode_q;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence iThenQ;
    iq_q ##1 !iq_q;
  endsequence
  sequence divBurst;
    (chan_q && valid_q) [*2] ##1 (!chan_q && valid_q) [*2] ##1 !valid_q;
  endsequence

  single_enable_a: assert property ((mode_q == MODE_SINGLE && !strobeS && !softRst_q) |=> !sValid_q)
    else $error("single real sample taken with strobe low");
  repeat_ignore_a: assert property ((mode_q != MODE_SINGLE && strobeS == prevStrobe_q) |=> !sValid_q)
    else $error("sample taken without strobe change");
  chan_tag_a: assert property ((sValid_q && $past(mode_q) == MODE_DIVERSITY) |-> sChanB_q == !$past(strobeS))
    else $error("diversity channel tag wrong");
  quad_pair_a: assert property ((sValid_q && sQuad_q) |-> sPairI_q == $past(iHold_q))
    else $error("quadrature not paired with last in-phase");
  flush_depth_a: assert property (softRst_q |=> !sValid_q throughout (primeCnt_q != PRIME_SAMPLES))
    else $error("sample passed before seven accepted");
  strap_frozen_a: assert property (strapDone_q |=> $stable(parMode_q))
    else $error("port mode changed after latch");
  scale_write_a: assert property ((wrAccess && paddr == SCALE_ADDR) |=> scale_q == $past(pwdata[2:0]))
    else $error("scale field not written");
  valid_len_a: assert property (($rose(valid_q) && !outDiv_q) |-> valid_q [*2] ##1 !valid_q)
    else $error("single burst valid length wrong");
  div_order_a: assert property (($rose(valid_q) && outDiv_q) |-> divBurst)
    else $error("diversity burst wrong");
  q_hold_a: assert property (!valid_q |=> (valid_q || $stable(outData_q)))
    else $error("output word changed while idle");
  iq_flag_a: assert property ($rose(valid_q) |-> iThenQ)
    else $error("I word not followed by Q word");
  idle_flags_a: assert property (!valid_q |-> (!iq_q && !chan_q))
    else $error("flags high while output idle");
endmodule // rx_ports

// ### bench/adc_model.sv
// Converter model driving the sample-input pins of the receive block.
// Assumes rate is an integer fraction of clk; pins change just after a rising edge.
`timescale 1ns/1ps
module adc_model
  import rx_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire inMode_t mode,
  input wire logic [3:0] rate,
  output logic [MANT_W-1:0] mantissa,
  output logic [EXP_W-1:0] exponent,
  output logic chanSelect
);
  logic [3:0] phase; // Clock position within one converter period
  logic [MANT_W-1:0] count; // Next sample value, also its index

  // One new sample per period; hold time ends after one clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 4'h0;
      count <= 16'h0;
      mantissa <= 16'h0;
      exponent <= 3'h0;
      chanSelect <= 1'b0;
    end else if (phase == 4'h0) begin
      // Exponent follows the low bits so the bench can pair them
      mantissa <= count;
      exponent <= count[2:0];
      if (mode == MODE_SINGLE) begin
        chanSelect <= 1'b1;
      end else begin
        chanSelect <= ~count[0];
      end
      count <= count + 16'h1;
      phase <= (rate > 4'h1) ? 4'h1 : 4'h0;
    end else begin
      // Data no longer valid: show a changing pattern, not the old value
      mantissa <= ~mantissa;
      exponent <= ~exponent;
      if (mode == MODE_SINGLE) begin
        chanSelect <= 1'b0;
      end
      // Wrap also when the rate drops below the current phase, so no long stall
      phase <= (phase + 4'h1 >= rate) ? 4'h0 : phase + 4'h1;
    end
  end
endmodule // adc_model

// ### bench/tb_top.sv
// Self-checking bench for the receiver input port and parallel output port.
// Assumes adc_model on the pins and an APB master written here.
`timescale 1ns/1ps
module tb_top;
  import rx_port_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [MANT_W-1:0] mantissa, sampleData, samplePairI;
  logic [EXP_W-1:0] exponent, sampleExp;
  logic chanSelect, outputPortSelect, sampleValid, sampleChanB, sampleQuad;
  logic resStrobe, outputValid, iqFlag, chanFlag, parallelEnable;
  logic [RES_W-1:0] resIA, resQA, resIB, resQB;
  logic [15:0] outData;
  inMode_t adcMode; // Pin pattern of the converter
  logic [3:0] adcRate; // Clocks per converter sample
  int mismatches, compares;

  rx_ports rx_ports_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mantissa(mantissa), .exponent(exponent), .chanSelect(chanSelect),
    .outputPortSelect(outputPortSelect), .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleExp(sampleExp), .sampleChanB(sampleChanB), .sampleQuad(sampleQuad),
    .samplePairI(samplePairI), .resStrobe(resStrobe), .resIA(resIA), .resQA(resQA),
    .resIB(resIB), .resQB(resQB), .outData(outData), .outputValid(outputValid),
    .iqFlag(iqFlag), .chanFlag(chanFlag), .parallelEnable(parallelEnable));
  adc_model adc_model_i (.clk(clk), .resetn(resetn), .mode(adcMode), .rate(adcRate),
    .mantissa(mantissa), .exponent(exponent), .chanSelect(chanSelect));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) mismatches++; // No answer within the limit
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected port word: arithmetic shift, then 16-bit saturation
  function automatic logic [15:0] scaleWord(input logic [22:0] v, input logic [2:0] s);
    logic signed [22:0] t;
    t = $signed(v) >>> s;
    if (t > 23'sd32767) return 16'h7fff;
    if (t < -23'sd32768) return 16'h8000;
    return t[15:0];
  endfunction

  // Reset values, read-write scale field, refused address
  task automatic reg_tests();
    apb(1'b0, STAT_ADDR, 32'h0);
    check("stat_par", rd[STAT_PAR_BIT], 32'h1);
    check("par_en", parallelEnable, 32'h1);
    apb(1'b0, SCALE_ADDR, 32'h0);
    check("scale_rst", rd, {29'h0, SCALE_RST});
    apb(1'b1, SCALE_ADDR, 32'hffff_fffd);
    apb(1'b0, SCALE_ADDR, 32'h0);
    check("scale_rw", rd, 32'h5);
    // Illegal mode code falls back to single real
    apb(1'b1, CTRL_ADDR, 32'h3);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("mode_illegal", rd, 32'h0);
    apb(1'b0, 14'h0100, 32'h0);
    check("unmapped_err", err, 32'h1);
    check("unmapped_rd", rd, 32'h0);
  endtask

  // Soft reset in a mode, flush delay, then eight accepted samples
  task automatic run_input(input inMode_t m, input logic [3:0] r);
    int n;
    logic [15:0] prev;
    adcMode <= m;
    adcRate <= r;
    apb(1'b1, CTRL_ADDR, 32'h100 | m);
    // Past the soft reset pulse, so a pulse of the old mode is not counted
    repeat (2) @(negedge clk);
    n = 0;
    while (sampleValid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("flush", n >= 7 * r && n <= 8 * r + 6, 32'h1);
    prev = sampleData;
    for (int k = 0; k < 8; k++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (sampleValid !== 1'b1 && n < 50);
      check("gap", n, r);
      check("data", sampleData, prev + 16'h1);
      check("exp", sampleExp, sampleData[2:0]);
      if (m == MODE_DIVERSITY) check("chan_b", sampleChanB, sampleData[0]);
      if (m == MODE_COMPLEX) check("quad", sampleQuad, sampleData[0]);
      if (m == MODE_COMPLEX && sampleData[0]) check("pair", samplePairI, prev);
      prev = sampleData;
    end
  endtask

  // One output burst: words, flags, valid length and the held Q word
  task automatic out_burst(input inMode_t m, input logic [2:0] sc);
    logic [22:0] w[4];
    int n;
    apb(1'b1, CTRL_ADDR, {30'h0, m});
    apb(1'b1, SCALE_ADDR, {29'h0, sc});
    w = '{resIA, resQA, resIB, resQB};
    n = (m == MODE_DIVERSITY) ? 4 : 2;
    @(posedge clk);
    resStrobe <= 1'b1;
    @(posedge clk);
    resStrobe <= 1'b0;
    @(negedge clk);
    for (int k = 0; k < 6 && outputValid !== 1'b1; k++) @(negedge clk);
    for (int k = 0; k < n; k++) begin
      check("valid", outputValid, 32'h1);
      check("word", outData, scaleWord(w[k], sc));
      check("iq", iqFlag, {31'h0, ~k[0]});
      check("chan", chanFlag, k < 2);
      @(negedge clk);
    end
    repeat (2) begin
      check("valid_end", outputValid, 32'h0);
      check("flags_low", {iqFlag, chanFlag}, 32'h0);
      check("q_hold", outData, scaleWord(w[n-1], sc));
      @(negedge clk);
    end
  endtask

  // Strap low at hard reset selects serial: no parallel bursts
  task automatic serial_mode();
    @(posedge clk);
    resetn <= 1'b0;
    // Strap moves only while reset is already low
    @(posedge clk);
    outputPortSelect <= 1'b0;
    repeat (11) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, STAT_ADDR, 32'h0);
    check("stat_ser", rd[STAT_PAR_BIT], 32'h0);
    resStrobe <= 1'b1;
    @(posedge clk);
    resStrobe <= 1'b0;
    repeat (6) begin
      @(negedge clk);
      check("ser_valid", outputValid, 32'h0);
    end
  endtask

  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    #500000;
    mismatches++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, resStrobe} = 4'h0;
    paddr = 14'h0;
    pwdata = 32'h0;
    outputPortSelect = 1'b1;
    adcMode = MODE_SINGLE;
    adcRate = 4'h1;
    resIA = 23'h000abc;
    resQA = 23'h7ffb10; // Negative word
    resIB = 23'h012340; // Saturates unless scaled down
    resQB = 23'h400000; // Most negative range
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    reg_tests();
    run_input(MODE_SINGLE, 4'h1);
    run_input(MODE_SINGLE, 4'h4);
    run_input(MODE_DIVERSITY, 4'h1);
    run_input(MODE_DIVERSITY, 4'h3);
    run_input(MODE_COMPLEX, 4'h1);
    out_burst(MODE_SINGLE, 3'h0);
    out_burst(MODE_DIVERSITY, 3'h2);
    out_burst(MODE_COMPLEX, 3'h7);
    serial_mode();
    final_report();
  end
endmodule // tb_top
